//--- rtl/readout_format_map.vh
`ifndef READOUT_FORMAT_MAP_VH
`define READOUT_FORMAT_MAP_VH
// register address and reset value
`define RFC_ADDR 8'h06
`define SOFT_RESET_ADDR 8'h00
`define BLACK_ACC_ADDR 8'h1A
`define RFC_RESET 8'h09
// field positions of the control and soft reset registers
`define RFC_LOW_RES 7
`define RFC_TIM_HI 6
`define RFC_TIM_LO 4
`define RFC_WIDTH_HI 3
`define RFC_WIDTH_LO 2
`define RFC_BLK_DIS 1
`define RFC_OFF_SPAN 0
`define SOFT_RESET_BIT 0
// converter and chip output resolutions in bits
`define ADC_BITS_LOW 3'h6
`define ADC_BITS_FULL 3'h5
`define CHIP_BITS_LOW 4'h9
`define CHIP_BITS_FULL 4'hd
// soft reset duration in pixel clocks
`define SOFT_RESET_CYCLES 3'h4
// timing select codes
`define TIM_HIGH_RES 3'h0
`define TIM_FIRST_LOW 3'h1
`define TIM_SECOND_2X2 3'h5
`define TIM_SECOND_3X4 3'h6
`define TIM_EXTERNAL 3'h7
// output width codes
`define WIDTH_13 2'h2
`define WIDTH_12 2'h3
// output width mode encodings
`define OWM_10 2'h0
`define OWM_13 2'h1
`define OWM_12 2'h2
// timing behaviour encodings
`define TB_HIGH 3'h0
`define TB_FIRST_LOW 3'h1
`define TB_SECOND_2X2 3'h2
`define TB_SECOND_3X4 3'h3
`define TB_EXTERNAL 3'h4
`define TB_UNDEFINED 3'h7
`endif

//--- rtl/readout_format_control.v
// Notes on behaviour
// - 8-bit read/write control register at offset 06h, resets to 09h.
// - bit 7 set gives 6-bit converter and 9-bit expanded output.
// - bits 6:4 choose timing mode: high, low resolution variants, external.
// - bits 3:2 choose output width: 0,1 ten bits, 2 thirteen, 3 twelve.
// - twelve-bit width saturates upper half of 13-bit range to max code.
// - ten-bit width maps 13-bit data through the programmable compander curve.
// - bit 1 clear runs the black-level loop, set halts it.
// - with loop halted, offset holds the accumulator's last value, from the loop or a software write.
// - bit 0 clear picks the 50 mV fine range, set the 100 mV range.
// - soft reset bit restores all defaults and clears after four pixel clocks.
`timescale 1ns/100ps
`default_nettype none
`include "readout_format_map.vh"
module readout_format_control #(
	parameter DATA_W = 13,
	parameter ACC_W = 8
) (
	input wire sys_clk, // pixel clock
	input wire arst_n, // asynchronous reset, active low
	input wire wr_en, // register write strobe
	input wire [7:0] wr_addr, // register write address
	input wire [7:0] wr_data, // register write data
	input wire [7:0] rd_addr, // register read address
	input wire [DATA_W-1:0] pix_in, // internal 13-bit pixel data
	input wire [9:0] comp_in, // compander curve result for pix_in
	input wire [ACC_W-1:0] loop_black, // black level computed by the loop
	output reg [7:0] rd_data, // register read data
	output reg soft_reset_active, // digital soft reset in progress
	output reg low_res, // reduced resolution operation
	output reg [2:0] adc_bits, // converter resolution in bits
	output reg [3:0] chip_bits, // chip output resolution in bits
	output reg [2:0] timing_mode, // decoded timing behaviour
	output reg timing_select_bit2, // timing select field bit 2
	output reg timing_select_bit1, // timing select field bit 1
	output reg timing_select_bit0, // timing select field bit 0
	output reg [1:0] output_width_select, // output width field
	output reg black_loop_run, // black-level loop enable
	output reg [ACC_W-1:0] black_offset, // offset applied to data
	output reg offset_span_wide, // larger offset range chosen
	output reg [DATA_W-1:0] pix_out // formatted output word
);
	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	reg [ACC_W-1:0] acc_q;
	reg [2:0] srst_cnt_q;
	wire [2:0] tim_sel;
	wire [1:0] width_sel;
	wire [1:0] width_mode;

	// decode of the timing select field
	function [2:0] decode_timing;
		input [2:0] code;
		begin
			case (code)
				`TIM_HIGH_RES: decode_timing = `TB_HIGH;
				`TIM_FIRST_LOW: decode_timing = `TB_FIRST_LOW;
				`TIM_SECOND_2X2: decode_timing = `TB_SECOND_2X2;
				`TIM_SECOND_3X4: decode_timing = `TB_SECOND_3X4;
				`TIM_EXTERNAL: decode_timing = `TB_EXTERNAL;
				default: decode_timing = `TB_UNDEFINED;
			endcase
		end
	endfunction

	// decode of the output width field
	function [1:0] decode_width;
		input [1:0] code;
		begin
			case (code)
				`WIDTH_13: decode_width = `OWM_13;
				`WIDTH_12: decode_width = `OWM_12;
				default: decode_width = `OWM_10;
			endcase
		end
	endfunction

	assign tim_sel = ctrl_q[`RFC_TIM_HI:`RFC_TIM_LO];
	assign width_sel = ctrl_q[`RFC_WIDTH_HI:`RFC_WIDTH_LO];
	assign width_mode = decode_width(width_sel);

	// next value of the control register
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_en && wr_addr == `RFC_ADDR) begin
			ctrl_d = wr_data;
		end
	end

	// soft reset request and progress, accumulator write strobe
	wire srst_busy;
	wire srst_req;
	wire acc_wr;
	assign srst_busy = (srst_cnt_q != 3'h0);
	assign srst_req = wr_en && (wr_addr == `SOFT_RESET_ADDR) && wr_data[`SOFT_RESET_BIT];
	assign acc_wr = wr_en && (wr_addr == `BLACK_ACC_ADDR);

	// soft reset sequencer: counts four pixel clocks, ignores writes meanwhile
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			srst_cnt_q <= 3'h0;
		end else if (srst_busy) begin
			srst_cnt_q <= srst_cnt_q - 3'h1;
		end else if (srst_req) begin
			srst_cnt_q <= `SOFT_RESET_CYCLES;
		end
	end

	// control register, forced to its default while soft reset runs
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `RFC_RESET;
		end else if (srst_busy || srst_req) begin
			ctrl_q <= `RFC_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// black level accumulator: a software write wins over the running loop
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= {ACC_W{1'b0}};
		end else if (srst_busy || srst_req) begin
			acc_q <= {ACC_W{1'b0}};
		end else if (acc_wr) begin
			acc_q <= wr_data[ACC_W-1:0];
		end else if (!ctrl_q[`RFC_BLK_DIS]) begin
			acc_q <= loop_black;
		end
	end

	// register read-back, one cycle behind the address
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= (rd_addr == `RFC_ADDR) ? ctrl_q : 8'h00;
		end
	end

	// soft reset status seen by the rest of the chip
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			soft_reset_active <= 1'b0;
		end else begin
			soft_reset_active <= srst_busy;
		end
	end

	// resolution outputs for the converter and the output stage
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			low_res <= 1'b0;
			adc_bits <= 3'h0;
			chip_bits <= 4'h0;
		end else begin
			low_res <= ctrl_q[`RFC_LOW_RES];
			adc_bits <= ctrl_q[`RFC_LOW_RES] ? `ADC_BITS_LOW : `ADC_BITS_FULL;
			chip_bits <= ctrl_q[`RFC_LOW_RES] ? `CHIP_BITS_LOW : `CHIP_BITS_FULL;
		end
	end

	// timing generator selection, raw field bits and decoded behaviour
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			timing_mode <= `TB_HIGH;
			timing_select_bit2 <= 1'b0;
			timing_select_bit1 <= 1'b0;
			timing_select_bit0 <= 1'b0;
		end else begin
			timing_mode <= decode_timing(tim_sel);
			timing_select_bit2 <= tim_sel[2];
			timing_select_bit1 <= tim_sel[1];
			timing_select_bit0 <= tim_sel[0];
		end
	end

	// output width field as seen by the formatter
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			output_width_select <= 2'h0;
		end else begin
			output_width_select <= width_sel;
		end
	end

	// black-level loop control and the offset it applies
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			black_loop_run <= 1'b0;
			black_offset <= {ACC_W{1'b0}};
		end else begin
			black_loop_run <= !ctrl_q[`RFC_BLK_DIS];
			black_offset <= acc_q;
		end
	end

	// offset cancellation range
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			offset_span_wide <= 1'b0;
		end else begin
			offset_span_wide <= ctrl_q[`RFC_OFF_SPAN];
		end
	end

	// output formatter: full width, saturated twelve bits or compander result
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pix_out <= {DATA_W{1'b0}};
		end else begin
			case (width_mode)
				`OWM_13: pix_out <= pix_in;
				`OWM_12: pix_out <= pix_in[DATA_W-1] ?
					{1'b0, {(DATA_W-1){1'b1}}} : pix_in;
				default: pix_out <= {{(DATA_W-10){1'b0}}, comp_in};
			endcase
		end
	end
endmodule
`default_nettype wire

//--- verification/readout_format_control_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rfc_sva (
	input wire sys_clk,
	input wire arst_n,
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [12:0] pix_in,
	input wire [9:0] comp_in,
	input wire soft_reset_active,
	input wire low_res,
	input wire timing_select_bit2,
	input wire timing_select_bit1,
	input wire timing_select_bit0,
	input wire [1:0] output_width_select,
	input wire black_loop_run,
	input wire offset_span_wide,
	input wire [12:0] pix_out
);
	// a control write made while soft_reset_active is low, including the cycle right after a soft reset request
	wire cw = wr_en && wr_addr == 8'h06 && !soft_reset_active;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_low_res_bit: assert property (cw |-> ##2 low_res == $past(wr_data[7], 2))
		else $error("low_res");
	a_tim_field: assert property (cw |-> ##2
		{timing_select_bit2, timing_select_bit1, timing_select_bit0} == $past(wr_data[6:4], 2))
		else $error("timing field");
	a_width_field: assert property (cw |-> ##2 output_width_select == $past(wr_data[3:2], 2))
		else $error("width field");
	a_loop_span: assert property (cw |-> ##2
		black_loop_run != $past(wr_data[1], 2) && offset_span_wide == $past(wr_data[0], 2))
		else $error("loop or span");
	a_full_pass: assert property ($past(arst_n) && output_width_select == 2'h2
		|-> pix_out == $past(pix_in)) else $error("full width");
	a_sat_twelve: assert property ($past(arst_n) && output_width_select == 2'h3
		|-> pix_out == ($past(pix_in[12]) ? 13'h0FFF : $past(pix_in))) else $error("twelve");
	a_compand_ten: assert property ($past(arst_n) && !output_width_select[1]
		|-> pix_out == {3'h0, $past(comp_in)}) else $error("ten");
	a_soft_len: assert property ($rose(soft_reset_active)
		|-> soft_reset_active[*4] ##1 !soft_reset_active) else $error("soft reset length");
endmodule
bind readout_format_control rfc_sva i_rfc_sva (.sys_clk, .arst_n, .wr_en, .wr_addr, .wr_data,
	.pix_in, .comp_in, .soft_reset_active, .low_res, .timing_select_bit2, .timing_select_bit1,
	.timing_select_bit0, .output_width_select, .black_loop_run, .offset_span_wide, .pix_out);
`default_nettype wire

//--- verification/tb_readout_format_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH %0t got %h want %h", $time, a, e); end end
module tb_readout_format_control;
	logic sys_clk = 0, arst_n = 0, wr_en = 0, soft_reset_active, low_res, black_loop_run;
	logic timing_select_bit2, timing_select_bit1, timing_select_bit0, offset_span_wide;
	logic [7:0] wr_addr = 0, wr_data = 0, rd_addr = 8'h06, rd_data, loop_black = 0, black_offset, d;
	logic [12:0] pix_in = 0, pix_out;
	logic [9:0] comp_in = 0;
	logic [2:0] adc_bits, timing_mode;
	logic [3:0] chip_bits;
	logic [1:0] output_width_select;
	logic [2:0] tmt [8] = '{3'h0, 3'h1, 3'h7, 3'h7, 3'h7, 3'h2, 3'h3, 3'h4};
	int seed = 69, num_errors = 0, tests_run = 0;
	readout_format_control i_readout_format_control (.sys_clk, .arst_n, .wr_en, .wr_addr, .wr_data,
		.rd_addr, .pix_in, .comp_in, .loop_black, .rd_data, .soft_reset_active, .low_res, .adc_bits,
		.chip_bits, .timing_mode, .timing_select_bit2, .timing_select_bit1, .timing_select_bit0,
		.output_width_select, .black_loop_run, .black_offset, .offset_span_wide, .pix_out);
	// clock and fresh data each cycle
	always #10 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		pix_in <= $random(seed);
		comp_in <= $random(seed);
		loop_black <= $random(seed);
	end
	// one write strobe
	task automatic wr(input [7:0] a, input [7:0] v);
		@(negedge sys_clk);
		{wr_en, wr_addr, wr_data} = {1'b1, a, v};
		@(negedge sys_clk);
		wr_en = 0;
	endtask
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// cut a hang short
	initial begin
		#50000;
		num_errors++;
		tally_and_finish;
	end
	// main sequence
	initial begin
		repeat (3) @(negedge sys_clk);
		arst_n = 1;
		repeat (2) @(negedge sys_clk);
		`CHK(rd_data, 8'h09)
		for (int i = 0; i < 40; i++) begin
			d = $random(seed);
			if (i < 8) d[6:4] = i;
			if (d[6:4] inside {3'h2, 3'h3, 3'h4}) d[6:4] = 3'h7;
			wr(8'h06, d);
			if (d[6:4] != 3'h0 && d[6:4] != 3'h7) wr(8'h1B, 8'h02);
			wr(8'h20, ~d);
			`CHK(rd_data, d)
			`CHK(timing_mode, tmt[d[6:4]])
			`CHK(chip_bits, d[7] ? 4'h9 : 4'hD)
			`CHK(adc_bits, d[7] ? 3'h6 : 3'h5)
		end
		wr(8'h06, 8'h0B);
		wr(8'h1A, 8'hA5);
		repeat (3) @(negedge sys_clk);
		`CHK(black_offset, 8'hA5)
		wr(8'h00, 8'h01);
		@(negedge sys_clk);
		`CHK(soft_reset_active, 1'b1)
		wr(8'h06, 8'hF0);
		rd_addr = 8'h20;
		repeat (6) @(negedge sys_clk);
		`CHK(rd_data, 8'h00)
		rd_addr = 8'h06;
		@(negedge sys_clk);
		`CHK(rd_data, 8'h09)
		tally_and_finish;
	end
endmodule
`default_nettype wire
